// ===== bench/eip_pin_src.sv
// Pin source model for the port 0 interrupt inputs.
// Assumes the bench names the level each pin should take.
`timescale 1ns/1ps
`default_nettype none
module eip_pin_src (
  input wire logic clk_sys,
  input wire logic [7:0] want,
  output logic [7:0] port0_pins
);
  initial port0_pins = 8'h00;
  // Each level is held until the bench asks for another
  always @(posedge clk_sys) port0_pins <= want;
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the pin select and polarity block.
// Assumes eip_pin_src drives the port 0 pins.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 0, reset = 1, clk_en = 1, sense_a = 0, sense_b = 0, ack = 0;
  eip_pkg::eip_sfr_req_t req = '0;
  logic [7:0] rdata, pins, want = 8'h00, cfg;
  logic pa, pb, aa, ab, hit;
  int error_cnt = 0, n_tests = 0, seed = 51;
  always #20 clk_sys = ~clk_sys;
  eip_pin_src u_src (.clk_sys(clk_sys), .want(want), .port0_pins(pins));
  eip_ext_irq u_dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .sfr_req(req),
    .sfr_rdata(rdata), .sfr_hit(hit), .port0_pins(pins), .sense_a(sense_a), .sense_b(sense_b),
    .vector_ack_a(ack), .vector_ack_b(ack), .ext_irq_a_pending(pa),
    .ext_irq_b_pending(pb), .ext_irq_a_active(aa), .ext_irq_b_active(ab));
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic sfr(logic wr, logic [7:0] addr, logic [7:0] d);
    @(posedge clk_sys);
    req <= '{wr: wr, rd: !wr, addr: addr, wdata: d};
    @(posedge clk_sys);
    req <= '0;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic settle(int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // Polarity-adjusted level of the pin a 4-bit field selects
  function automatic logic sel(logic [7:0] p, logic [3:0] f);
    return f[3] ? p[f[2:0]] : !p[f[2:0]];
  endfunction
  task automatic finish_test();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 0;
    sfr(1'b0, eip_pkg::EIP_CFG_ADDR, 8'h00);
    check("cfg reset", rdata, eip_pkg::EIP_CFG_RESET);
    for (int i = 0; i < 40; i++) begin
      cfg = 8'($random(seed));
      sfr(1'b1, eip_pkg::EIP_CFG_ADDR, cfg);
      sfr(1'b1, 8'he5, ~cfg);
      sfr(1'b0, 8'he5, 8'h00);
      check("unmapped", rdata, 8'h00);
      sfr(1'b0, eip_pkg::EIP_CFG_ADDR, 8'h00);
      check("cfg", rdata, cfg);
      want <= 8'($random(seed));
      settle(6);
      check("active", {6'h00, ab, aa}, {6'h00, sel(want, cfg[7:4]), sel(want, cfg[3:0])});
      check("level", {6'h00, pb, pa}, {6'h00, sel(want, cfg[7:4]), sel(want, cfg[3:0])});
      req <= '{wr: 1'b0, rd: 1'b0, addr: (i[0] ? eip_pkg::EIP_CFG_ADDR : cfg), wdata: 8'h00};
      #1;
      check("hit", {7'h00, hit}, {7'h00, i[0] || cfg == eip_pkg::EIP_CFG_ADDR});
      req <= '0;
    end
    sense_a <= 1;
    sense_b <= 1;
    sfr(1'b1, eip_pkg::EIP_CFG_ADDR, 8'h88);
    want <= 8'h00;
    settle(6);
    ack <= 1;
    settle(1);
    ack <= 0;
    want <= 8'h01;
    settle(6);
    check("edge set", {6'h00, pb, pa}, 8'h03);
    ack <= 1;
    settle(1);
    ack <= 0;
    settle(2);
    check("edge clear", {6'h00, pb, pa}, 8'h00);
    want <= 8'h00;
    settle(6);
    want <= 8'h01;
    settle(4);
    ack <= 1;
    settle(1);
    ack <= 0;
    check("set wins", {6'h00, pb, pa}, 8'h03);
    clk_en <= 0;
    sfr(1'b1, eip_pkg::EIP_CFG_ADDR, 8'h5a);
    clk_en <= 1;
    sfr(1'b0, eip_pkg::EIP_CFG_ADDR, 8'h00);
    check("frozen cfg", rdata, 8'h88);
    reset <= 1;
    settle(2);
    check("reset pend", {6'h00, pb, pa}, 8'h00);
    reset <= 0;
    sfr(1'b0, eip_pkg::EIP_CFG_ADDR, 8'h00);
    check("cfg re-reset", rdata, eip_pkg::EIP_CFG_RESET);
    finish_test();
  end
  initial begin
    #200us;
    error_cnt++;
    finish_test();
  end
endmodule
`default_nettype wire

// ===== core/eip_ext_irq.sv
// External interrupt pin selection, polarity and pending flag logic.
// Assumes port 0 pins arrive asynchronously; sense bits come from the timer control register.
//
// Contract
// RL1 - Polarity bit 0 active low, 1 active high
// RL2 - Field bits 6:4 selects pin for input b
// RL3 - Field bits 2:0 selects pin for input a
// RL4 - Register at 0xE4, read/write, resets zero
// RL5 - Edge or level taken from timer control
// RL6 - Edge pending cleared when CPU vectors
// RL7 - Level pending follows adjusted input level
// RL8 - Source holds input until request recognized
// RL9 - Pins sampled without disturbing other peripherals
//
// Pins are taken as idle high through reset, so no false edge follows it.
// A config write may itself raise the adjusted level and latch an edge.
`timescale 1ns/1ps
`default_nettype none

module eip_ext_irq (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire eip_pkg::eip_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic [7:0] port0_pins,
  input wire logic sense_a,
  input wire logic sense_b,
  input wire logic vector_ack_a,
  input wire logic vector_ack_b,
  output logic ext_irq_a_pending,
  output logic ext_irq_b_pending,
  output logic ext_irq_a_active,
  output logic ext_irq_b_active
);
  eip_pkg::eip_cfg_t cfg_reg, cfg_next;
  logic [7:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
  logic [1:0] lvl_reg, lvl_next, prev_reg, prev_next, pend_reg, pend_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [1:0] sense, ack;
  logic sel_hit;

  function automatic logic pick(input logic [7:0] pins, input logic [2:0] sel, input logic pol);
    pick = pol ? pins[sel] : ~pins[sel];
  endfunction

  assign sense = {sense_b, sense_a};
  assign ack = {vector_ack_b, vector_ack_a};
  assign sel_hit = (sfr_req.addr == eip_pkg::EIP_CFG_ADDR);

  always_comb begin
    cfg_next = cfg_reg;
    rdata_next = rdata_reg;
    if (sfr_req.wr && sel_hit) begin
      cfg_next = sfr_req.wdata; // [RL4]
    end
    if (sfr_req.rd) begin
      rdata_next = sel_hit ? cfg_reg : eip_pkg::EIP_UNMAPPED_DATA; // [RL4]
    end
  end

  // Input only: the pins are never driven here, so other users are unaffected
  always_comb begin
    sync1_next = port0_pins; // [RL9]
    sync2_next = sync1_reg;
    lvl_next[0] = pick(sync2_reg, cfg_reg.a_sel, cfg_reg.a_pol); // [RL1] [RL3]
    lvl_next[1] = pick(sync2_reg, cfg_reg.b_sel, cfg_reg.b_pol); // [RL1] [RL2]
    prev_next = lvl_reg;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pend
      always_comb begin
        if (sense[gi] == eip_pkg::EIP_EDGE) begin // [RL5]
          if (lvl_reg[gi] && !prev_reg[gi]) begin
            pend_next[gi] = 1'b1; // Set wins over vector clear
          end else if (ack[gi]) begin
            pend_next[gi] = 1'b0; // [RL6]
          end else begin
            pend_next[gi] = pend_reg[gi];
          end
        end else begin
          pend_next[gi] = lvl_reg[gi]; // [RL7]
        end
      end
    end
  endgenerate

  // Register group: configuration byte and read data
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cfg_reg <= eip_pkg::EIP_CFG_RESET; // [RL4]
      rdata_reg <= eip_pkg::EIP_RDATA_RESET;
    end else if (clk_en) begin
      cfg_reg <= cfg_next;
      rdata_reg <= rdata_next;
    end
  end

  // Synchroniser group: only the second stage reads the first
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sync1_reg <= eip_pkg::EIP_PIN_IDLE;
      sync2_reg <= eip_pkg::EIP_PIN_IDLE;
    end else if (clk_en) begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  // Level group: adjusted level and its previous value for edge detection
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lvl_reg <= 2'h0;
      prev_reg <= 2'h0;
    end else if (clk_en) begin
      lvl_reg <= lvl_next;
      prev_reg <= prev_next;
    end
  end

  // Pending group
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pend_reg <= 2'h0;
    end else if (clk_en) begin
      pend_reg <= pend_next;
    end
  end

  assign sfr_rdata = rdata_reg;
  assign sfr_hit = sel_hit;
  assign ext_irq_a_pending = pend_reg[0];
  assign ext_irq_b_pending = pend_reg[1];
  assign ext_irq_a_active = lvl_reg[0];
  assign ext_irq_b_active = lvl_reg[1];

  sequence s_rise_a;
    clk_en && lvl_reg[0] && !prev_reg[0];
  endsequence

  chk_cfg_write: assert property (@(posedge clk_sys) disable iff (reset) // [RL4]
    clk_en && sfr_req.wr && sel_hit |=> cfg_reg == $past(sfr_req.wdata))
    else $error("config write not stored");
  chk_read_back: assert property (@(posedge clk_sys) disable iff (reset) // [RL4]
    clk_en && sfr_req.rd && sel_hit |=> sfr_rdata == $past(cfg_reg))
    else $error("config readback wrong");
  chk_a_select: assert property (@(posedge clk_sys) disable iff (reset) // [RL3]
    clk_en |=> lvl_reg[0] == ($past(cfg_reg.a_pol) ~^ $past(sync2_reg[cfg_reg.a_sel])))
    else $error("input a selection wrong");
  chk_b_select: assert property (@(posedge clk_sys) disable iff (reset) // [RL2]
    clk_en |=> lvl_reg[1] == ($past(cfg_reg.b_pol) ~^ $past(sync2_reg[cfg_reg.b_sel])))
    else $error("input b selection wrong");
  chk_pol_low: assert property (@(posedge clk_sys) disable iff (reset) // [RL1]
    clk_en && !cfg_reg.a_pol && !sync2_reg[cfg_reg.a_sel] |=> lvl_reg[0])
    else $error("active low polarity wrong");
  chk_level_track: assert property (@(posedge clk_sys) disable iff (reset) // [RL7]
    clk_en && sense_a == eip_pkg::EIP_LEVEL |=> ext_irq_a_pending == $past(lvl_reg[0]))
    else $error("level pending not tracking");
  chk_edge_set: assert property (@(posedge clk_sys) disable iff (reset) // [RL5]
    s_rise_a ##0 (sense_a == eip_pkg::EIP_EDGE) |=> ext_irq_a_pending)
    else $error("edge not latched");
  chk_edge_clear: assert property (@(posedge clk_sys) disable iff (reset) // [RL6]
    clk_en && sense_b && vector_ack_b && !(lvl_reg[1] && !prev_reg[1]) |=> !ext_irq_b_pending)
    else $error("vector did not clear pending");

  sequence s_rise_b;
    clk_en && lvl_reg[1] && !prev_reg[1];
  endsequence

  sequence s_vector_a;
    clk_en && vector_ack_a && !(lvl_reg[0] && !prev_reg[0]);
  endsequence

  sequence s_collide_a;
    s_rise_a ##0 (vector_ack_a && sense_a == eip_pkg::EIP_EDGE);
  endsequence

  // Register access and clock enable freeze checks
  chk_unmapped_read: assert property (@(posedge clk_sys) disable iff (reset) // [RL4]
    clk_en && sfr_req.rd && !sel_hit |=> sfr_rdata == eip_pkg::EIP_UNMAPPED_DATA)
    else $error("unmapped read not zero");
  chk_write_other: assert property (@(posedge clk_sys) disable iff (reset) // [RL4]
    clk_en && sfr_req.wr && !sel_hit |=> $stable(cfg_reg))
    else $error("foreign write changed config");
  chk_rdata_hold: assert property (@(posedge clk_sys) disable iff (reset) // [RL4]
    clk_en && !sfr_req.rd |=> $stable(sfr_rdata))
    else $error("read data changed without read");
  chk_freeze_state: assert property (@(posedge clk_sys) disable iff (reset) // [RL4]
    !clk_en |=> $stable(cfg_reg) && $stable(pend_reg) && $stable(lvl_reg))
    else $error("state moved while enable low");

  // Pin path and polarity checks
  chk_sync_path: assert property (@(posedge clk_sys) disable iff (reset) // [RL9]
    clk_en |=> sync2_reg == $past(sync1_reg))
    else $error("synchroniser stage skipped");
  chk_pol_high: assert property (@(posedge clk_sys) disable iff (reset) // [RL1]
    clk_en && cfg_reg.a_pol && sync2_reg[cfg_reg.a_sel] |=> lvl_reg[0])
    else $error("active high polarity wrong");
  chk_b_pol_low: assert property (@(posedge clk_sys) disable iff (reset) // [RL1]
    clk_en && !cfg_reg.b_pol && !sync2_reg[cfg_reg.b_sel] |=> lvl_reg[1])
    else $error("input b active low wrong");
  chk_b_pol_high: assert property (@(posedge clk_sys) disable iff (reset) // [RL1]
    clk_en && cfg_reg.b_pol && !sync2_reg[cfg_reg.b_sel] |=> !lvl_reg[1])
    else $error("input b active high wrong");

  // Pending flag checks
  chk_b_level: assert property (@(posedge clk_sys) disable iff (reset) // [RL7]
    clk_en && sense_b == eip_pkg::EIP_LEVEL |=> ext_irq_b_pending == $past(lvl_reg[1]))
    else $error("level pending b not tracking");
  chk_b_edge_set: assert property (@(posedge clk_sys) disable iff (reset) // [RL5]
    s_rise_b ##0 (sense_b == eip_pkg::EIP_EDGE) |=> ext_irq_b_pending)
    else $error("edge b not latched");
  chk_a_edge_clear: assert property (@(posedge clk_sys) disable iff (reset) // [RL6]
    s_vector_a ##0 (sense_a == eip_pkg::EIP_EDGE) |=> !ext_irq_a_pending)
    else $error("vector did not clear pending a");
  chk_set_wins: assert property (@(posedge clk_sys) disable iff (reset) // [RL6]
    s_collide_a |=> ext_irq_a_pending)
    else $error("set lost to vector clear");
  chk_edge_hold: assert property (@(posedge clk_sys) disable iff (reset) // [RL5]
    clk_en && sense_a == eip_pkg::EIP_EDGE && !vector_ack_a && !(lvl_reg[0] && !prev_reg[0])
    |=> ext_irq_a_pending == $past(ext_irq_a_pending))
    else $error("edge pending changed without cause");
  chk_edge_no_level: assert property (@(posedge clk_sys) disable iff (reset) // [RL5]
    clk_en && sense_b == eip_pkg::EIP_EDGE && !lvl_reg[1] && !vector_ack_b
    && ext_irq_b_pending |=> ext_irq_b_pending)
    else $error("edge pending b followed level");
endmodule

`default_nettype wire

// ===== inc/eip_pkg.sv
// Package for the external interrupt pin select and polarity block.
// Assumes an 8-bit special function register bus with byte addresses.
package eip_pkg;
  localparam logic [7:0] EIP_CFG_ADDR = 8'he4;
  localparam logic [7:0] EIP_CFG_RESET = 8'h00;
  localparam logic [7:0] EIP_RDATA_RESET = 8'h00;
  localparam logic [7:0] EIP_UNMAPPED_DATA = 8'h00;
  localparam logic [7:0] EIP_PIN_IDLE = 8'hff;
  localparam int EIP_B_POL_BIT = 7;
  localparam int EIP_B_SEL_LSB = 4;
  localparam int EIP_A_POL_BIT = 3;
  localparam int EIP_A_SEL_LSB = 0;
  localparam int EIP_SEL_W = 3;

  typedef struct packed {
    logic b_pol;
    logic [2:0] b_sel;
    logic a_pol;
    logic [2:0] a_sel;
  } eip_cfg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eip_sfr_req_t;

  typedef enum logic [0:0] {
    EIP_LEVEL = 1'b0,
    EIP_EDGE = 1'b1
  } eip_sense_t;
endpackage
